// ### rscc_consts.svh
`ifndef RSCC_CONSTS_SVH
`define RSCC_CONSTS_SVH
// ---------------------------------------------------------------
// Register location
// ---------------------------------------------------------------
`define RSCC_SFR_PAGE     4'h0
`define RSCC_SFR_ADDR     8'hEF
// ---------------------------------------------------------------
// Bit positions of the reset cause control register
// ---------------------------------------------------------------
`define RSCC_B_RTC        7
`define RSCC_B_FLASH      6
`define RSCC_B_CMP        5
`define RSCC_B_SW         4
`define RSCC_B_WDT        3
`define RSCC_B_MCD        2
`define RSCC_B_PF         1
`define RSCC_B_PIN        0
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RSCC_CAUSE_POR    8'h02
`define RSCC_CMP_EN_RST   1'b0
`define RSCC_RTC_EN_RST   1'b0
`define RSCC_MCD_EN_RST   1'b1
`define RSCC_PF_EN_RST    1'b1
`define RSCC_SYNC_RST     6'h01
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RSCC_CLK_MHZ      25
`define RSCC_MCD_TIME_US  100
`define RSCC_MCD_CYC      (`RSCC_MCD_TIME_US * `RSCC_CLK_MHZ)
`define RSCC_WDT_DIV      12
`endif

// ### rscc_pkg.sv
package rscc_pkg;
  // Sequencer states
  typedef enum logic {RSCC_RUN, RSCC_HOLD} rscc_state_e;
  // One register byte
  typedef logic [7:0] rscc_byte_t;
endpackage

// ### rscc_reset_source_controller.sv
// What this block does
// RULE1 - Register bit 5 written 1 enables comparator reset, 0 disables it.
// RULE2 - Enabled comparator with plus input below minus input resets device.
// RULE3 - Comparator flag reads 1 only after a comparator caused reset.
// RULE4 - In low power, comparator reset works only if comparator wakeup enabled.
// RULE5 - Software lets the comparator settle before enabling its reset.
// RULE6 - After any reset the watchdog is enabled, clocked at clock over 12.
// RULE7 - Unserviced watchdog resets device and sets read-only flag bit 3.
// RULE8 - Watchdog reset is off in low power and restored on exit.
// RULE9 - Illegal flash accesses, or flash writes without supply monitor, reset.
// RULE10 - Flash error reset sets read-only flag bit 6.
// RULE11 - Clock oscillator failure or alarm match raise a clock reset event.
// RULE12 - Bit 7 enables clock reset; reads 1 after a clock caused reset.
// RULE13 - Clock reset keeps working in suspend and sleep.
// RULE14 - Writing 1 to bit 4 forces reset; bit then reads 1.
// RULE15 - Internal resets never drive or change the external reset pin.
// RULE16 - Bit 2 enables missing clock detector; reads 1 after its timeout.
// RULE17 - Bit 1 enables supply monitor reset; reads 1 after power or supply reset.
// RULE18 - While power flag reads 1 the other bits are not to be trusted.
// RULE19 - Software waits for supply monitor to settle before enabling it.
// RULE20 - Bit 0 is read-only and reads 1 after an external pin reset.
// RULE21 - Written-back flag bits never trigger resets, except software force.
// RULE22 - The register sits at page 0x0, address 0xEF.
// RULE23 - Clock stuck longer than 100 us with detector enabled causes reset. The code does not raise this reset while low_power is high.
// RULE24 - Each reset latches exactly one cause flag, all others read 0.
`include "rscc_consts.svh"
module rscc_reset_source_controller
  import rscc_pkg::*;
#(
  parameter int              HOLD_CYC  = 8,
  parameter int              ADDR_W    = 16,
  parameter logic [15:0]     LOCK_ADDR = 16'hF7FF
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        sfr_page,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic [7:0]             sfr_rdata_ff,
  input  wire logic              ext_rst_pin_n,
  input  wire logic              cmp_below,
  input  wire logic              cmp_wake_en,
  input  wire logic              supply_low,
  input  wire logic              rtc_osc_fail,
  input  wire logic              rtc_alarm,
  input  wire logic              clk_heartbeat,
  input  wire logic              low_power,
  input  wire logic              wdt_timeout,
  input  wire logic              wdt_sw_enable,
  input  wire logic              wdt_sw_disable,
  input  wire logic              flash_write_req,
  input  wire logic              flash_write_en,
  input  wire logic              code_read_req,
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] access_addr,
  input  wire logic              security_block,
  output logic                   sys_reset_ff,
  output logic                   wdt_enable_ff,
  output logic                   wdt_tick_ff
);
  // ---------------------------------------------------------------
  // Constants and checks
  // ---------------------------------------------------------------
  localparam logic [11:0] MCD_LIM  = 12'(`RSCC_MCD_CYC);
  localparam logic [3:0]  WDT_LAST = 4'(`RSCC_WDT_DIV - 1);
  localparam logic [7:0]  HOLD_END = 8'(HOLD_CYC - 1);

  if (HOLD_CYC < 8 || HOLD_CYC > 255) begin : g_bad_hold
    $error("HOLD_CYC must lie in 8..255");
  end
  if (ADDR_W != 16) begin : g_bad_addr
    $error("ADDR_W must be 16");
  end

  // Address above the lock byte
  function automatic logic above_lock(input logic [ADDR_W-1:0] a);
    return a > LOCK_ADDR;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;

  // Pin is only sampled, never driven (see RULE15)
  always_comb begin
    nxt_sync1 = {clk_heartbeat, rtc_alarm, rtc_osc_fail,
                 supply_low, cmp_below, ext_rst_pin_n};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_ff <= `RSCC_SYNC_RST;
      sync2_ff <= `RSCC_SYNC_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rscc_state_e state_ff, nxt_state;
  logic [7:0]  hold_cnt_ff, nxt_hold_cnt;
  rscc_byte_t  cause_ff, nxt_cause, nxt_rdata;
  logic        cmp_en_ff, rtc_en_ff, mcd_en_ff, pf_en_ff, wdt_en_ff;
  logic        nxt_cmp_en, nxt_rtc_en, nxt_mcd_en, nxt_pf_en, nxt_wdt_en;
  logic        nxt_sys_reset, nxt_wdt_out;
  logic [11:0] mcd_cnt_ff, nxt_mcd_cnt;
  logic        hb_prev_ff;
  logic [3:0]  div_cnt_ff, nxt_div_cnt;
  logic        nxt_tick;

  // Register decode at its page and address (see RULE22)
  logic sfr_hit, wr_hit, rd_hit;
  assign sfr_hit = (sfr_page == `RSCC_SFR_PAGE) &&
                   (sfr_addr == `RSCC_SFR_ADDR);
  assign wr_hit  = sfr_wr && sfr_hit && (state_ff == RSCC_RUN);
  assign rd_hit  = sfr_rd && sfr_hit;

  // ---------------------------------------------------------------
  // Reset triggers
  // ---------------------------------------------------------------
  logic pin_trig, pf_trig, flash_trig, mcd_trig, wdt_trig;
  logic cmp_trig, rtc_trig, sw_trig, any_trig;

  assign pin_trig   = ~sync2_ff[0];                      // see RULE20
  assign pf_trig    = pf_en_ff & sync2_ff[2];            // see RULE17
  // Illegal flash access kinds (see RULE9)
  assign flash_trig = (flash_write_req & flash_write_en &
                       (above_lock(access_addr) | ~pf_en_ff)) |
                      (code_read_req & above_lock(access_addr)) |
                      (fetch_req & above_lock(access_addr)) |
                      security_block;
  // Stuck clock beyond the limit (see RULE16) (see RULE23)
  assign mcd_trig   = mcd_en_ff & ~low_power & (mcd_cnt_ff > MCD_LIM);
  assign wdt_trig   = wdt_en_ff & ~low_power & wdt_timeout;  // see RULE8
  // Comparator, kept in low power only with wakeup (see RULE2) (see RULE4)
  assign cmp_trig   = cmp_en_ff & sync2_ff[1] &
                      (~low_power | cmp_wake_en);
  // Clock events, not gated by low power (see RULE11) (see RULE13)
  assign rtc_trig   = rtc_en_ff & (sync2_ff[3] | sync2_ff[4]);
  // Only the force bit of a write triggers (see RULE14) (see RULE21)
  assign sw_trig    = wr_hit & sfr_wdata[`RSCC_B_SW];
  assign any_trig   = pin_trig | pf_trig | flash_trig | mcd_trig |
                      wdt_trig | cmp_trig | rtc_trig | sw_trig;

  // ---------------------------------------------------------------
  // Sequencer, cause latch and enables
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_hold_cnt  = hold_cnt_ff;
    nxt_cause     = cause_ff;
    nxt_sys_reset = sys_reset_ff;
    nxt_cmp_en    = cmp_en_ff;
    nxt_rtc_en    = rtc_en_ff;
    nxt_mcd_en    = mcd_en_ff;
    nxt_pf_en     = pf_en_ff;
    nxt_wdt_en    = wdt_en_ff;
    unique case (state_ff)
      RSCC_RUN: begin
        if (any_trig) begin
          nxt_state     = RSCC_HOLD;
          nxt_hold_cnt  = 8'h00;
          nxt_sys_reset = 1'b1;
          nxt_cmp_en    = `RSCC_CMP_EN_RST;
          nxt_rtc_en    = `RSCC_RTC_EN_RST;
          nxt_mcd_en    = `RSCC_MCD_EN_RST;
          nxt_pf_en     = `RSCC_PF_EN_RST;
          nxt_wdt_en    = 1'b1;                      // see RULE6
          // One cause only, fixed priority (see RULE24) (see RULE3)
          nxt_cause = 8'h00;
          if (pin_trig) begin
            nxt_cause[`RSCC_B_PIN] = 1'b1;
          end else if (pf_trig) begin
            nxt_cause[`RSCC_B_PF] = 1'b1;
          end else if (flash_trig) begin
            nxt_cause[`RSCC_B_FLASH] = 1'b1;           // see RULE10
          end else if (mcd_trig) begin
            nxt_cause[`RSCC_B_MCD] = 1'b1;
          end else if (wdt_trig) begin
            nxt_cause[`RSCC_B_WDT] = 1'b1;             // see RULE7
          end else if (cmp_trig) begin
            nxt_cause[`RSCC_B_CMP] = 1'b1;
          end else if (rtc_trig) begin
            nxt_cause[`RSCC_B_RTC] = 1'b1;             // see RULE12
          end else begin
            nxt_cause[`RSCC_B_SW] = 1'b1;
          end
        end else begin
          // Enable bits; flag bits written back are ignored (see RULE21)
          if (wr_hit) begin
            nxt_cmp_en = sfr_wdata[`RSCC_B_CMP];       // see RULE1
            nxt_rtc_en = sfr_wdata[`RSCC_B_RTC];       // see RULE12
            nxt_mcd_en = sfr_wdata[`RSCC_B_MCD];       // see RULE16
            nxt_pf_en  = sfr_wdata[`RSCC_B_PF];        // see RULE17
          end
          if (wdt_sw_disable) begin
            nxt_wdt_en = 1'b0;
          end else if (wdt_sw_enable) begin
            nxt_wdt_en = 1'b1;
          end
        end
      end
      RSCC_HOLD: begin
        if (hold_cnt_ff == HOLD_END) begin
          nxt_state     = RSCC_RUN;
          nxt_sys_reset = 1'b0;
        end else begin
          nxt_hold_cnt = hold_cnt_ff + 8'h01;
        end
      end
    endcase
    // Stored enable survives low power untouched (see RULE8)
    nxt_wdt_out = nxt_wdt_en & ~low_power;
    nxt_rdata   = rd_hit ? cause_ff : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff      <= RSCC_RUN;
      hold_cnt_ff   <= 8'h00;
      cause_ff      <= `RSCC_CAUSE_POR;   // see RULE17 (see RULE18)
      sys_reset_ff  <= 1'b0;
      cmp_en_ff     <= `RSCC_CMP_EN_RST;
      rtc_en_ff     <= `RSCC_RTC_EN_RST;
      mcd_en_ff     <= `RSCC_MCD_EN_RST;
      pf_en_ff      <= `RSCC_PF_EN_RST;
      wdt_en_ff     <= 1'b1;                        // see RULE6
      wdt_enable_ff <= 1'b0;
      sfr_rdata_ff  <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      hold_cnt_ff   <= nxt_hold_cnt;
      cause_ff      <= nxt_cause;
      sys_reset_ff  <= nxt_sys_reset;
      cmp_en_ff     <= nxt_cmp_en;
      rtc_en_ff     <= nxt_rtc_en;
      mcd_en_ff     <= nxt_mcd_en;
      pf_en_ff      <= nxt_pf_en;
      wdt_en_ff     <= nxt_wdt_en;
      wdt_enable_ff <= nxt_wdt_out;
      sfr_rdata_ff  <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Missing clock timer and watchdog prescaler
  // ---------------------------------------------------------------
  always_comb begin
    // Restart on each heartbeat edge (see RULE23)
    if ((sync2_ff[5] ^ hb_prev_ff) || !mcd_en_ff ||
        state_ff == RSCC_HOLD) begin
      nxt_mcd_cnt = 12'h000;
    end else if (mcd_cnt_ff > MCD_LIM) begin
      nxt_mcd_cnt = mcd_cnt_ff;
    end else begin
      nxt_mcd_cnt = mcd_cnt_ff + 12'h001;
    end
    // Clock over twelve (see RULE6)
    nxt_tick    = (div_cnt_ff == WDT_LAST);
    nxt_div_cnt = nxt_tick ? 4'h0 : div_cnt_ff + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcd_cnt_ff  <= 12'h000;
      hb_prev_ff  <= 1'b0;
      div_cnt_ff  <= 4'h0;
      wdt_tick_ff <= 1'b0;
    end else begin
      mcd_cnt_ff  <= nxt_mcd_cnt;
      hb_prev_ff  <= sync2_ff[5];
      div_cnt_ff  <= nxt_div_cnt;
      wdt_tick_ff <= nxt_tick;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_cmp_enable_wr: assert property (
    wr_hit && !any_trig |=> cmp_en_ff == $past(sfr_wdata[`RSCC_B_CMP])
  ) else $error("comparator enable not written"); // see RULE1
  a_cmp_trigger: assert property (
    state_ff == RSCC_RUN && cmp_en_ff && sync2_ff[1] && !low_power
    |=> sys_reset_ff ##0 (cause_ff[`RSCC_B_CMP] || cause_ff[`RSCC_B_PIN] ||
        cause_ff[`RSCC_B_PF] || cause_ff[`RSCC_B_FLASH] ||
        cause_ff[`RSCC_B_MCD] || cause_ff[`RSCC_B_WDT])
  ) else $error("comparator reset missed"); // see RULE2
  a_cause_onehot: assert property (
    $rose(sys_reset_ff) |-> $onehot(cause_ff)
  ) else $error("cause not one-hot"); // see RULE24
  a_wdt_after_rst: assert property (
    $fell(sys_reset_ff) |-> wdt_en_ff ##1 (wdt_enable_ff || $past(low_power))
  ) else $error("watchdog off after reset"); // see RULE6
  a_wdt_tick_gap: assert property (
    wdt_tick_ff |=> !wdt_tick_ff[*8] ##1 !wdt_tick_ff[*3] ##1 wdt_tick_ff
  ) else $error("watchdog tick spacing wrong"); // see RULE6
  a_wdt_low_pwr: assert property (
    low_power |=> !wdt_enable_ff
  ) else $error("watchdog on in low power"); // see RULE8
  a_flash_flag: assert property (
    state_ff == RSCC_RUN && flash_trig && !pin_trig && !pf_trig
    |=> sys_reset_ff && cause_ff == 8'h40
  ) else $error("flash error flag wrong"); // see RULE10
  a_sw_force: assert property (
    sw_trig && !(pin_trig || pf_trig || flash_trig || mcd_trig ||
                 wdt_trig || cmp_trig || rtc_trig)
    |=> sys_reset_ff && cause_ff == 8'h10
  ) else $error("software force failed"); // see RULE14
  a_rtc_low_pwr: assert property (
    state_ff == RSCC_RUN && rtc_trig && low_power |=> sys_reset_ff
  ) else $error("clock reset lost in low power"); // see RULE13
  a_reg_read: assert property (
    rd_hit |=> sfr_rdata_ff == $past(cause_ff)
  ) else $error("register read wrong"); // see RULE22
  a_hold_length: assert property (
    $rose(sys_reset_ff) |-> sys_reset_ff[*8]
  ) else $error("reset pulse too short"); // see RULE24

  c_cmp_reset: cover property ($rose(sys_reset_ff) && cause_ff[`RSCC_B_CMP]);
  c_wdt_reset: cover property ($rose(sys_reset_ff) && cause_ff[`RSCC_B_WDT]);
  c_sw_reset:  cover property ($rose(sys_reset_ff) && cause_ff[`RSCC_B_SW]);
  c_pin_reset: cover property ($rose(sys_reset_ff) && cause_ff[`RSCC_B_PIN]);
endmodule // rscc_reset_source_controller

// ### rscc_src_model.sv
// ----
// Far side: monitored system clock source
// ----
module rscc_src_model (
  input  wire logic clk,
  input  wire logic run,
  output logic      heartbeat
);
  timeunit 1ns;
  timeprecision 1ps;
  // Toggles while running, stands still when the clock is lost
  initial heartbeat = 1'b0;
  always @(posedge clk) begin
    if (run) begin
      heartbeat <= ~heartbeat;
    end
  end
endmodule // rscc_src_model

// ### reset_source_controller_tb_top.sv
module reset_source_controller_tb_top import rscc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  logic       clk, sys_rst, sfr_wr, sfr_rd, ext_rst_pin_n, cmp_below;
  logic       cmp_wake_en, supply_low, rtc_osc_fail, rtc_alarm, low_power;
  logic       wdt_timeout, wdt_sw_enable, wdt_sw_disable, flash_write_req;
  logic       flash_write_en, code_read_req, fetch_req, security_block;
  logic       hb_run, clk_heartbeat, sys_reset_ff, wdt_enable_ff, wdt_tick_ff;
  logic [3:0] sfr_page;
  logic [7:0] sfr_addr;
  logic [15:0] access_addr;
  rscc_byte_t sfr_wdata, sfr_rdata_ff, rd;
  int         num_errors, n_checks;
  time        t0;
  // ----
  // Design and far side
  // ----
  rscc_reset_source_controller #(.HOLD_CYC(HOLD)) u_dut (
    .clk, .sys_rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata_ff, .ext_rst_pin_n, .cmp_below, .cmp_wake_en, .supply_low,
    .rtc_osc_fail, .rtc_alarm, .clk_heartbeat, .low_power, .wdt_timeout,
    .wdt_sw_enable, .wdt_sw_disable, .flash_write_req, .flash_write_en,
    .code_read_req, .fetch_req, .access_addr, .security_block,
    .sys_reset_ff, .wdt_enable_ff, .wdt_tick_ff);
  rscc_src_model u_src (.clk(clk), .run(hb_run), .heartbeat(clk_heartbeat));
  // ----
  // Clock and watchdog
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(20000 * 40);
    num_errors++;
    stop_test();
  end
  // ----
  // Helpers
  // ----
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp8(input rscc_byte_t got, input rscc_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input rscc_byte_t d);
    @(negedge clk);
    sfr_addr  = 8'hEF;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output rscc_byte_t d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata_ff;
  endtask
  // No internal reset may rise for n cycles
  task automatic no_rst(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      seen |= (sys_reset_ff !== 1'b0);
    end
    cmp8({7'h00, seen}, 8'h00);
  endtask
  // Wait for reset, check its length, then read the cause byte
  task automatic expect_rst(input rscc_byte_t exp, input bit chk);
    int w;
    int h;
    w = 0;
    h = 0;
    while (sys_reset_ff !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    while (sys_reset_ff === 1'b1 && h < 300) begin
      @(negedge clk);
      h++;
    end
    if (chk) cmp8(8'(h), 8'(HOLD));
    reg_rd(8'hEF, rd);
    cmp8(rd, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_por;
    reg_rd(8'hEF, rd);
    cmp8(rd, 8'h02);
    cmp8({7'h00, wdt_enable_ff}, 8'h01);
    reg_rd(8'hEE, rd);
    cmp8(rd, 8'h00);
    sfr_page = 4'h1;
    reg_rd(8'hEF, rd);
    cmp8(rd, 8'h00);
    sfr_page = 4'h0;
    @(posedge wdt_tick_ff);
    t0 = $time;
    @(posedge wdt_tick_ff);
    cmp8(8'(($time - t0) / 40), 8'h0C);
  endtask
  task automatic t_sw;
    @(negedge clk) wdt_sw_disable = 1'b1;
    @(negedge clk) wdt_sw_disable = 1'b0;
    cmp8({7'h00, wdt_enable_ff}, 8'h00);
    reg_wr(8'h16);
    expect_rst(8'h10, 1'b1);
    cmp8({7'h00, wdt_enable_ff}, 8'h01);
    reg_wr(8'h4F);
    no_rst(12);
    reg_rd(8'hEF, rd);
    cmp8(rd, 8'h10);
  endtask
  task automatic t_cmp;
    cmp_below = 1'b1;
    no_rst(10);
    cmp_below = 1'b0;
    reg_wr(8'h26);
    low_power = 1'b1;
    cmp_below = 1'b1;
    no_rst(10);
    cmp_wake_en = 1'b1;
    expect_rst(8'h20, 1'b1);
    cmp_below   = 1'b0;
    cmp_wake_en = 1'b0;
    low_power   = 1'b0;
  endtask
  task automatic t_wdt;
    @(negedge clk) low_power = 1'b1;
    @(negedge clk) wdt_timeout = 1'b1;
    @(negedge clk) wdt_timeout = 1'b0;
    cmp8({7'h00, wdt_enable_ff}, 8'h00);
    no_rst(10);
    low_power = 1'b0;
    repeat (2) @(negedge clk);
    cmp8({7'h00, wdt_enable_ff}, 8'h01);
    wdt_sw_disable = 1'b1;
    @(negedge clk) wdt_sw_disable = 1'b0;
    wdt_timeout = 1'b1;
    @(negedge clk) wdt_timeout = 1'b0;
    cmp8({7'h00, wdt_enable_ff}, 8'h00);
    no_rst(4);
    wdt_sw_enable = 1'b1;
    @(negedge clk) wdt_sw_enable = 1'b0;
    cmp8({7'h00, wdt_enable_ff}, 8'h01);
    wdt_timeout = 1'b1;
    @(negedge clk) wdt_timeout = 1'b0;
    expect_rst(8'h08, 1'b1);
  endtask
  task automatic t_flash;
    access_addr   = 16'hF7FF;
    code_read_req = 1'b1;
    fetch_req     = 1'b1;
    no_rst(3);
    access_addr = 16'hF800;
    fetch_req   = 1'b0;
    @(negedge clk) code_read_req = 1'b0;
    expect_rst(8'h40, 1'b1);
    fetch_req = 1'b1;
    @(negedge clk) fetch_req = 1'b0;
    expect_rst(8'h40, 1'b1);
    security_block = 1'b1;
    @(negedge clk) security_block = 1'b0;
    expect_rst(8'h40, 1'b1);
    reg_wr(8'h04);
    access_addr     = 16'h0100;
    flash_write_en  = 1'b1;
    flash_write_req = 1'b1;
    @(negedge clk) flash_write_req = 1'b0;
    flash_write_en = 1'b0;
    expect_rst(8'h40, 1'b1);
  endtask
  task automatic t_rtc;
    reg_wr(8'h86);
    low_power = 1'b1;
    rtc_alarm = 1'b1;
    expect_rst(8'h80, 1'b1);
    rtc_alarm = 1'b0;
    low_power = 1'b0;
    reg_wr(8'h86);
    rtc_osc_fail = 1'b1;
    expect_rst(8'h80, 1'b1);
    rtc_osc_fail = 1'b0;
  endtask
  task automatic t_pf;
    supply_low = 1'b1;
    repeat (3) @(negedge clk);
    supply_low = 1'b0;
    expect_rst(8'h02, 1'b1);
    reg_wr(8'h00);
    supply_low = 1'b1;
    rtc_alarm  = 1'b1;
    no_rst(10);
    supply_low = 1'b0;
    rtc_alarm  = 1'b0;
  endtask
  task automatic t_pin_mcd;
    ext_rst_pin_n = 1'b0;
    repeat (2) @(negedge clk);
    ext_rst_pin_n = 1'b1;
    expect_rst(8'h01, 1'b0);
    hb_run = 1'b0;
    expect_rst(8'h04, 1'b1);
    hb_run = 1'b1;
    reg_wr(8'h02);
    hb_run = 1'b0;
    no_rst(2700);
    hb_run = 1'b1;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {sfr_wr, sfr_rd, cmp_below, cmp_wake_en, supply_low} = '0;
    {rtc_osc_fail, rtc_alarm, low_power, wdt_timeout} = '0;
    {wdt_sw_enable, wdt_sw_disable, flash_write_req, flash_write_en} = '0;
    {code_read_req, fetch_req, security_block} = '0;
    {sfr_page, sfr_addr, sfr_wdata, access_addr} = '0;
    {num_errors, n_checks} = '0;
    ext_rst_pin_n = 1'b1;
    hb_run        = 1'b1;
    sys_rst       = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_por();
    t_sw();
    t_cmp();
    t_wdt();
    t_flash();
    t_rtc();
    t_pf();
    t_pin_mcd();
    stop_test();
  end
endmodule // reset_source_controller_tb_top
